// file: inc/safety_input_pkg.sv
// Behaviour
// - stop output is 0 while button pressed, 1 when released.
// - stop takes one NC channel or two NC channels.
// - guard output is 0 while open, 1 while closed.
// - guard takes two NC, or NO on channel one with NC on two.
// - with reset enabled, every trip latches output 0 until valid reset.
// - without reset, output follows the qualified input directly.
// - manual reset type accepts a single 0 to 1 transition.
// - monitored reset type accepts only a full 0-1-0 pulse.
// - output test drives test signals and checks each returns its own.
// - start-up test keeps output 0 until one full actuation after power-up.
// - stop test is press then release; guard test is open then close.
// - each contact passes a 3 to 250 ms debounce filter.
// - two channels must switch within the configured simultaneity time.
// - stop simultaneity only applies with two NC channels.
// - fault output, when enabled, shows any detected fault.
package safety_input_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_FILTER    = 8'h04;
  localparam logic [7:0] ADDR_SIMUL     = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h10;

  // per-function field layout: byte 0 stop, byte 1 guard; simultaneity uses 16-bit halves, low stop, high guard
  localparam int FN_COUNT     = 2;
  localparam int FN_STOP      = 0;
  localparam int FN_GUARD     = 1;
  localparam int CFG_W        = 7;
  localparam int CFG_STRIDE   = 8;
  localparam int FILTER_W     = 8;
  localparam int SIMUL_W      = 16;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] FILTER_RST = 16'h0303;
  localparam logic [31:0] SIMUL_RST  = 32'h0064_0064;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 20;
  localparam logic [FILTER_W-1:0] FILTER_MIN_MS = 8'h03;
  localparam logic [FILTER_W-1:0] FILTER_MAX_MS = 8'hFA;

  // test pulse sequencer: 2-bit channel slot, 4-bit phase
  localparam int TP_W = 6;
  localparam logic [3:0] TP_LOW_END = 4'hC;
  localparam logic [3:0] TP_CHECK   = 4'hB;

  typedef struct packed {
    logic fault_out_en;
    logic simul_en;
    logic startup_en;
    logic out_test_en;
    logic monitored;
    logic reset_en;
    logic dual_cfg;
  } fn_cfg_t;

  typedef struct packed {
    logic reset_lvl;
    logic ch2_lvl;
    logic ch1_lvl;
    logic started;
    logic test_fault;
    logic sim_fault;
    logic fault;
    logic out;
  } fn_status_t;

  typedef enum {
    S_START_WAIT_TRIP,
    S_START_WAIT_SAFE,
    S_TRIPPED,
    S_WAIT_RESET,
    S_ON
  } mon_state_t;

endpackage

// file: design/contact_filter.sv
`timescale 1ns/10ps
module contact_filter
  import safety_input_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // pin and timing
  input  wire logic                pin,
  input  wire logic                ms_tick,
  input  wire logic [FILTER_W-1:0] filter_ms,
  // test pulse control
  input  wire logic                hold,
  input  wire logic                check,
  // results
  output logic                     level_q,
  output logic                     mismatch_q
);

  logic                s1_q, s2_q, s3_q;
  logic                stable_q, stable_d;
  logic [FILTER_W-1:0] cnt_q, cnt_d;
  logic                level_d;
  logic                mismatch_d;

  always_comb begin
    stable_d   = (s2_q == s3_q) ? s3_q : stable_q;
    cnt_d      = cnt_q;
    level_d    = level_q;
    // a returned test pulse must read low
    mismatch_d = check & stable_q;
    if (hold || stable_q == level_q) begin
      cnt_d = '0;
    end else if (ms_tick) begin
      if (cnt_q + 8'h01 >= filter_ms) begin
        level_d = stable_q;
        cnt_d   = '0;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q       <= 1'b0;
      s2_q       <= 1'b0;
      s3_q       <= 1'b0;
      stable_q   <= 1'b0;
      cnt_q      <= '0;
      level_q    <= 1'b0;
      mismatch_q <= 1'b0;
    end else begin
      s1_q       <= pin;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      stable_q   <= stable_d;
      cnt_q      <= cnt_d;
      level_q    <= level_d;
      mismatch_q <= mismatch_d;
    end
  end

endmodule

// file: design/safety_input_monitor.sv
`timescale 1ns/10ps
module safety_input_monitor
  import safety_input_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // apb slave
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // contacts, index 0 stop, 1 guard
  input  wire logic [FN_COUNT-1:0] contact_channel_one,
  input  wire logic [FN_COUNT-1:0] contact_channel_two,
  input  wire logic [FN_COUNT-1:0] reset_in,
  // test signals onto the contact lines
  output logic [FN_COUNT-1:0]      test_channel_one,
  output logic [FN_COUNT-1:0]      test_channel_two,
  // function results
  output logic [FN_COUNT-1:0]      safe_out,
  output logic [FN_COUNT-1:0]      fault_out
);

  localparam int NCH = 3 * FN_COUNT;

  // register file
  logic [31:0]         ctrl_q, ctrl_d;
  logic [15:0]         filter_q, filter_d;
  logic [31:0]         simul_q, simul_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;
  logic [FN_COUNT-1:0] fault_clr;
  logic [31:0]         status_word;

  // timing
  logic [TICK_W-1:0]   tick_cnt_q, tick_cnt_d;
  logic                ms_tick_q, ms_tick_d;
  logic [TP_W-1:0]     tp_q, tp_d;
  logic [3:0]          test_low_q, test_low_d;

  // channel results: 0..3 contacts, 4..5 reset inputs
  logic [NCH-1:0]      ch_pin, ch_hold, ch_check, ch_lvl, ch_mism;
  logic [FILTER_W-1:0] ch_filter [NCH];

  fn_cfg_t             cfg [FN_COUNT];
  fn_status_t          stat [FN_COUNT];
  logic [FN_COUNT-1:0] safe_d, fault_out_d;

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign ch_pin    = {reset_in, contact_channel_two[1], contact_channel_one[1],
                      contact_channel_two[0], contact_channel_one[0]};

  function automatic logic [FILTER_W-1:0] clamp_ms(
    input logic [FILTER_W-1:0] v
  );
    // out-of-range settings are clamped, so none can shorten the debounce below 3 ms
    if (v < FILTER_MIN_MS) begin
      return FILTER_MIN_MS;
    end else if (v > FILTER_MAX_MS) begin
      return FILTER_MAX_MS;
    end
    return v;
  endfunction

  // ---------------- apb slave ----------------
  always_comb begin
    logic acc;
    logic mapped;
    logic [31:0] rd;
    acc       = psel & penable;
    mapped    = 1'b1;
    rd        = 32'h0000_0000;
    ctrl_d    = ctrl_q;
    filter_d  = filter_q;
    simul_d   = simul_q;
    fault_clr = '0;
    unique case (paddr)
      ADDR_CTRL:      rd = ctrl_q;
      ADDR_FILTER:    rd = {16'h0000, filter_q};
      ADDR_SIMUL:     rd = simul_q;
      ADDR_STATUS:    rd = status_word;
      ADDR_FAULT_CLR: rd = 32'h0000_0000;
      default:        mapped = 1'b0;
    endcase
    // one wait state: answer on the second access cycle
    pready_d  = acc & ~pready_q;
    pslverr_d = acc & ~pready_q & ~mapped;
    prdata_d  = (acc & ~pready_q & ~pwrite) ? rd : 32'h0000_0000;
    if (acc && pready_q && pwrite) begin
      unique case (paddr)
        ADDR_CTRL:      ctrl_d    = pwdata;
        ADDR_FILTER:    filter_d  = pwdata[15:0];
        ADDR_SIMUL:     simul_d   = pwdata;
        ADDR_FAULT_CLR: fault_clr = pwdata[FN_COUNT-1:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q    <= CTRL_RST;
      filter_q  <= FILTER_RST;
      simul_q   <= SIMUL_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      filter_q  <= filter_d;
      simul_q   <= simul_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------- millisecond tick and test pulses ----------------
  always_comb begin
    ms_tick_d  = 1'b0;
    tick_cnt_d = tick_cnt_q + 20'h00001;
    if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      ms_tick_d  = 1'b1;
    end
    tp_d       = tp_q + 6'h01;
    test_low_d = '0;
    // staggered pulses, so a short to any other line reads high
    for (int c = 0; c < 4; c++) begin
      // a pulse only starts at phase 0, so enabling mid-slot never cuts one
      test_low_d[c] = cfg[c / 2].out_test_en && tp_d[5:4] == 2'(c)
                      && tp_d[3:0] < TP_LOW_END
                      && (tp_d[3:0] == 4'h0 || test_low_q[c]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
      tp_q       <= '0;
      test_low_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ms_tick_q  <= ms_tick_d;
      tp_q       <= tp_d;
      test_low_q <= test_low_d;
    end
  end

  assign test_channel_one = ~{test_low_q[2], test_low_q[0]};
  assign test_channel_two = ~{test_low_q[3], test_low_q[1]};

  // ---------------- input conditioning ----------------
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      if (c < 4) begin : g_contact
        assign ch_filter[c] = clamp_ms(filter_q[FILTER_W*(c/2) +: FILTER_W]);
        // hold the filter level and clear its count over its own pulse and the recovery after it
        assign ch_hold[c]   = cfg[c / 2].out_test_en && tp_q[5:4] == 2'(c);
        assign ch_check[c]  = ch_hold[c] && tp_q[3:0] == TP_CHECK
                              && test_low_q[c];
      end else begin : g_reset
        assign ch_filter[c] = FILTER_MIN_MS;
        assign ch_hold[c]   = 1'b0;
        assign ch_check[c]  = 1'b0;
      end
      contact_filter u_filter (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .pin        (ch_pin[c]),
        .ms_tick    (ms_tick_q),
        .filter_ms  (ch_filter[c]),
        .hold       (ch_hold[c]),
        .check      (ch_check[c]),
        .level_q    (ch_lvl[c]),
        .mismatch_q (ch_mism[c])
      );
    end
  endgenerate

  // ---------------- monitor functions ----------------
  genvar f;
  generate
    for (f = 0; f < FN_COUNT; f++) begin : g_fn
      mon_state_t         state_q, state_d;
      logic [SIMUL_W-1:0] sim_cnt_q, sim_cnt_d;
      logic               sim_fault_q, sim_fault_d;
      logic               test_fault_q, test_fault_d;
      logic               rst_prev_q, rst_prev_d;
      logic               armed_q, armed_d;
      logic               started_q, started_d;
      logic               seen_safe_q, seen_safe_d;
      logic               two, safe1, safe2, both_safe, both_unsafe;
      logic               qualified, accept;

      assign cfg[f] = fn_cfg_t'(ctrl_q[CFG_STRIDE*f +: CFG_W]);
      // guard always two channels; stop only in dual mode
      assign two    = (f == FN_GUARD) | cfg[f].dual_cfg;
      // mixed guard: normally open contact sits on channel one
      assign safe1  = ch_lvl[2*f] ^ ((f == FN_GUARD) & cfg[f].dual_cfg);
      assign safe2  = ch_lvl[2*f+1];
      // every used channel must report safe
      assign both_safe   = safe1 & (safe2 | ~two);
      assign both_unsafe = ~safe1 & (~safe2 | ~two);

      always_comb begin
        logic fault_now;
        fault_now    = 1'b0;
        sim_cnt_d    = '0;
        sim_fault_d  = sim_fault_q;
        test_fault_d = (test_fault_q & ~fault_clr[f])
                       | ch_mism[2*f] | ch_mism[2*f+1];
        if (two && cfg[f].simul_en && safe1 != safe2) begin
          sim_cnt_d = sim_cnt_q;
          if (ms_tick_q) begin
            sim_cnt_d = sim_cnt_q + 16'h0001;
          end
          if (sim_cnt_q > simul_q[SIMUL_W*f +: SIMUL_W]) begin
            sim_fault_d = 1'b1;
          end
        end
        // cleared only once both channels went unsafe
        if (both_unsafe) begin
          sim_fault_d = 1'b0;
        end
        fault_now = sim_fault_q | test_fault_q;
        // a fault forces the output off
        qualified = both_safe & ~fault_now;

        rst_prev_d = ch_lvl[4+f];
        armed_d    = armed_q;
        accept     = 1'b0;
        if (state_q != S_WAIT_RESET) begin
          armed_d = 1'b0;
        end else if (!cfg[f].monitored) begin
          accept = ch_lvl[4+f] & ~rst_prev_q;
        end else if (ch_lvl[4+f] & ~rst_prev_q) begin
          armed_d = 1'b1;
        end else if (armed_q & ~ch_lvl[4+f] & rst_prev_q) begin
          accept = 1'b1;
        end

        state_d     = state_q;
        started_d   = started_q;
        // filters read low after reset; a trip counts only after safe
        seen_safe_d = seen_safe_q | both_safe;
        unique case (state_q)
          // trip first: press, or open the guard
          S_START_WAIT_TRIP: begin
            if (!cfg[f].startup_en) begin
              state_d = S_TRIPPED;
            end else if (both_unsafe && seen_safe_q) begin
              state_d = S_START_WAIT_SAFE;
            end
          end
          // then release, or close the guard
          S_START_WAIT_SAFE: begin
            if (qualified) begin
              started_d = 1'b1;
              state_d   = cfg[f].reset_en ? S_WAIT_RESET : S_ON;
            end
          end
          // without reset the output follows qualified input
          S_TRIPPED: begin
            // start-up test still owed since power-up
            if (cfg[f].startup_en && !started_q) begin
              state_d = S_START_WAIT_TRIP;
            end else if (qualified) begin
              state_d = cfg[f].reset_en ? S_WAIT_RESET : S_ON;
            end
          end
          // latched off until a valid reset
          S_WAIT_RESET: begin
            if (!qualified) begin
              state_d = S_TRIPPED;
            end else if (accept) begin
              state_d = S_ON;
            end
          end
          S_ON: begin
            if (!qualified || (cfg[f].startup_en && !started_q)) begin
              state_d = S_TRIPPED;
            end
          end
        endcase
        safe_d[f]      = state_d == S_ON;
        fault_out_d[f] = cfg[f].fault_out_en & (sim_fault_d | test_fault_d);
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          state_q      <= S_START_WAIT_TRIP;
          sim_cnt_q    <= '0;
          sim_fault_q  <= 1'b0;
          test_fault_q <= 1'b0;
          rst_prev_q   <= 1'b0;
          armed_q      <= 1'b0;
          started_q    <= 1'b0;
          seen_safe_q  <= 1'b0;
        end else begin
          state_q      <= state_d;
          sim_cnt_q    <= sim_cnt_d;
          sim_fault_q  <= sim_fault_d;
          test_fault_q <= test_fault_d;
          rst_prev_q   <= rst_prev_d;
          armed_q      <= armed_d;
          started_q    <= started_d;
          seen_safe_q  <= seen_safe_d;
        end
      end

      assign stat[f] = '{reset_lvl:  ch_lvl[4+f],
                         ch2_lvl:    ch_lvl[2*f+1],
                         ch1_lvl:    ch_lvl[2*f],
                         started:    started_q,
                         test_fault: test_fault_q,
                         sim_fault:  sim_fault_q,
                         fault:      sim_fault_q | test_fault_q,
                         out:        safe_out[f]};
    end
  endgenerate

  assign status_word = {16'h0000, stat[1], stat[0]};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      safe_out  <= '0;
      fault_out <= '0;
    end else begin
      safe_out  <= safe_d;
      fault_out <= fault_out_d;
    end
  end

endmodule

// file: verification/safety_input_monitor_assertions.sv
`timescale 1ns/10ps
module safety_input_monitor_assertions
  import safety_input_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input logic                ref_clk,
  input logic                nrst,
  // apb
  input logic [7:0]          paddr,
  input logic                psel,
  input logic                penable,
  input logic                pwrite,
  input logic [31:0]         pwdata,
  input logic [31:0]         prdata,
  input logic                pready,
  input logic                pslverr,
  // pins and results
  input logic [FN_COUNT-1:0] contact_channel_one,
  input logic [FN_COUNT-1:0] contact_channel_two,
  input logic [FN_COUNT-1:0] reset_in,
  input logic [FN_COUNT-1:0] test_channel_one,
  input logic [FN_COUNT-1:0] test_channel_two,
  input logic [FN_COUNT-1:0] safe_out,
  input logic [FN_COUNT-1:0] fault_out
);
  // bound covers the longest filter plus slot pauses
  localparam int unsigned LOW_LIM = 260 * TICK_CYCLES;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  int unsigned low_q;
  int unsigned low_d;
  always_comb begin
    ctrl_d = ctrl_q;
    if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata[15:0];
    end
    low_d = contact_channel_one[0] ? 0 : low_q + 1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 16'h0000;
      low_q  <= 0;
    end else begin
      ctrl_q <= ctrl_d;
      low_q  <= low_d;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  chk_ready_wait: assert property (psel && $rose(penable) |->
    !pready ##1 pready) else $error("pready not on second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_stop_trip: assert property (low_q > LOW_LIM |-> !safe_out[0])
    else $error("stop output high while pressed");
  chk_fault_off: assert property (fault_out[0] [*3] |-> !safe_out[0])
    else $error("stop output high during fault");
  chk_fault_gate: assert property (
    !ctrl_q[6] && !$past(ctrl_q[6]) |-> !fault_out[0])
    else $error("fault output while disabled");
  chk_pulse_len: assert property ($fell(test_channel_one[0]) |->
    (!test_channel_one[0]) [*8] ##1 (!test_channel_one[0]) [*4]
    ##1 test_channel_one[0]) else $error("test pulse length wrong");
  chk_manual_reset: assert property ($rose(safe_out[0]) &&
    ctrl_q[2:1] == 2'b01 |-> reset_in[0])
    else $error("manual reset accepted without rise");
  chk_monitor_reset: assert property ($rose(safe_out[0]) &&
    ctrl_q[2:1] == 2'b11 |-> !reset_in[0])
    else $error("monitored reset accepted before fall");
  cov_sim_fault: cover property ($rose(fault_out[0]));
  cov_reset_ok: cover property ($rose(safe_out[0]) && ctrl_q[1]);
  cov_guard_on: cover property ($rose(safe_out[1]));
endmodule

bind safety_input_monitor safety_input_monitor_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .reset_in(reset_in),
  .contact_channel_one(contact_channel_one),
  .contact_channel_two(contact_channel_two),
  .test_channel_one(test_channel_one), .test_channel_two(test_channel_two),
  .safe_out(safe_out), .fault_out(fault_out)
);

// file: verification/safety_contact_model.sv
`timescale 1ns/10ps
module safety_contact_model
  import safety_input_pkg::*;
(
  // actuation, 1 = pressed or open
  input  logic [FN_COUNT-1:0] act_one,
  input  logic [FN_COUNT-1:0] act_two,
  // channel one shorted to supply
  input  logic [FN_COUNT-1:0] short_one,
  // test signals from the monitor
  input  logic [FN_COUNT-1:0] test_channel_one,
  input  logic [FN_COUNT-1:0] test_channel_two,
  // lines are pulled down while the contact is open
  output logic [FN_COUNT-1:0] contact_channel_one,
  output logic [FN_COUNT-1:0] contact_channel_two
);
  logic [FN_COUNT-1:0] closed_one;
  // stop contacts NC, guard channel one NO
  assign closed_one = {act_one[FN_GUARD], ~act_one[FN_STOP]};
  // closed contact returns its test signal
  assign contact_channel_one = (closed_one & test_channel_one) | short_one;
  assign contact_channel_two = ~act_two & test_channel_two;
endmodule

// file: verification/safety_input_monitor_tb.sv
`timescale 1ns/10ps
module safety_input_monitor_tb
  import safety_input_pkg::*;
;
  // short tick keeps millisecond counts cheap
  localparam int TICK = 10;
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] exp;
    logic        err;
  } row_t;
  row_t rows [4] = '{
    '{ADDR_CTRL, CTRL_RST, 1'b0},
    '{ADDR_FILTER, {16'h0000, FILTER_RST}, 1'b0},
    '{ADDR_SIMUL, SIMUL_RST, 1'b0},
    '{8'h14, 32'h0000_0000, 1'b1}
  };
  logic                ref_clk;
  logic                nrst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic                pready;
  logic                pslverr;
  logic                er;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic [31:0]         rd;
  logic [FN_COUNT-1:0] ch_one, ch_two, rst_in, t_one, t_two, safe, flt;
  logic [FN_COUNT-1:0] act_one, act_two, short_one;
  int                  err_total = 0;
  int                  total_checks = 0;
  int                  cyc = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // idle cycle first so no strobe is driven twice in one step
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  safety_input_monitor #(.TICK_CYCLES(TICK)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_channel_one(ch_one), .contact_channel_two(ch_two),
    // reset button sits beside its contacts
    .reset_in(rst_in), .test_channel_one(t_one),
    .test_channel_two(t_two), .safe_out(safe), .fault_out(flt)
  );

  safety_contact_model i_far (
    .act_one(act_one), .act_two(act_two), .short_one(short_one),
    .test_channel_one(t_one), .test_channel_two(t_two),
    .contact_channel_one(ch_one), .contact_channel_two(ch_two)
  );

  initial begin
    nrst      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    rst_in    = 2'b00;
    act_one   = 2'b00;
    act_two   = 2'b00;
    short_one = 2'b00;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b0, 32'h0000_0000);
      check("rdata", rd, rows[i].exp);
      check("pslverr", 32'(er), 32'(rows[i].err));
    end
    apb(ADDR_FILTER, 1'b1, 32'h0000_FF01);
    apb(ADDR_FILTER, 1'b0, 32'h0000_0000);
    check("filter", rd, 32'h0000_FF01); // raw setting kept
    apb(ADDR_FILTER, 1'b1, 32'h0000_0303);
    $display("registers done");
    // guard in mixed wiring, both follow their inputs
    apb(ADDR_CTRL, 1'b1, 32'h0000_0100);
    wait_cy(100);
    check("safe", 32'(safe), 32'h0000_0003); // closed
    act_one <= 2'b11;
    act_two <= 2'b10;
    wait_cy(2700);
    check("safe", 32'(safe), 32'h0000_0000); // tripped
    $display("follow done");
    for (int m = 0; m < 2; m++) begin
      apb(ADDR_CTRL, 1'b1, m ? 32'h0000_0006 : 32'h0000_0002);
      act_one[0] <= 1'b1;
      wait_cy(100);
      act_one[0] <= 1'b0;
      wait_cy(100);
      check("latched", 32'(safe[0]), 32'h0000_0000); // latch
      rst_in[0] <= 1'b1;
      wait_cy(80);
      check("reset high", 32'(safe[0]), 32'(!m)); // edge
      rst_in[0] <= 1'b0;
      wait_cy(100);
      check("reset done", 32'(safe[0]), 32'h0000_0001); // pulse
    end
    $display("reset types done");
    apb(ADDR_SIMUL, 1'b1, 32'h0064_0005);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0061);
    wait_cy(100);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h1); // both
    act_one[0] <= 1'b1;
    wait_cy(200);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h2); // skew
    act_one[0] <= 1'b0;
    wait_cy(200);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h2); // held
    act_one[0] <= 1'b1;
    act_two[0] <= 1'b1;
    wait_cy(100);
    act_one[0] <= 1'b0;
    act_two[0] <= 1'b0;
    wait_cy(100);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h1); // clear
    $display("simultaneity done");
    apb(ADDR_CTRL, 1'b1, 32'h0000_0048);
    wait_cy(200);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h1); // clean
    short_one[0] <= 1'b1;
    wait_cy(200);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h2); // short
    short_one[0] <= 1'b0;
    wait_cy(100);
    apb(ADDR_FAULT_CLR, 1'b1, 32'h0000_0001);
    wait_cy(100);
    check("fault safe", 32'({flt[0], safe[0]}), 32'h1); // clear
    $display("output test done");
    nrst <= 1'b0;
    wait_cy(2);
    check("reset pins", 32'({safe, flt, t_one, t_two}), 32'h0000_000F);
    nrst <= 1'b1;
    apb(ADDR_CTRL, 1'b0, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0000);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0010);
    wait_cy(100);
    check("startup", 32'(safe[0]), 32'h0000_0000); // held off
    act_one[0] <= 1'b1;
    wait_cy(100);
    act_one[0] <= 1'b0;
    wait_cy(100);
    check("startup", 32'(safe[0]), 32'h0000_0001); // press release
    $display("reset done");
    wrap_up();
  end
endmodule
